// ---- dsp_pkg.sv ----
// package: datapath widths, microcode layout, register map and state record
package dsp_pkg;
  localparam int DW = 16;             // datapath word width
  localparam int DMEM_WORDS = 128;    // data memory locations
  localparam int DA_W = 7;            // data memory address width
  localparam int UC_WORDS = 256;      // microcode words
  localparam int PC_W = 8;            // microcode address width
  localparam int IX_W = 8;            // index register width

  // byte offsets of the register window (word index = address[9:2])
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_STATUS   = 12'h004;
  localparam logic [11:0] OFS_MAIN_LEN = 12'h008;
  localparam logic [11:0] OFS_SUB_LEN  = 12'h00c;
  localparam logic [11:0] OFS_ITER_MOD = 12'h010;
  localparam logic [11:0] OFS_IY_MOD   = 12'h014;
  localparam logic [11:0] OFS_FSM_REF  = 12'h018;
  localparam logic [11:0] OFS_RESULT   = 12'h01c;
  localparam logic [1:0]  REG_REGION   = 2'h0;
  localparam logic [1:0]  DMEM_REGION  = 2'h1;  // 0x400..0x5fc
  localparam logic [1:0]  UC_REGION    = 2'h2;  // 0x800..0xbfc

  // reset values
  localparam logic [PC_W-1:0] MAIN_LEN_RST = 8'h01;
  localparam logic [PC_W-1:0] SUB_LEN_RST  = 8'h01;
  localparam logic [IX_W-1:0] ITER_MOD_RST = 8'h01;
  localparam logic [IX_W-1:0] IY_MOD_RST   = 8'h01;

  // selector codes
  localparam logic [1:0] MOR_HOLD = 2'h0, MOR_READ = 2'h1, MOR_INV_MIR = 2'h2;
  localparam logic [1:0] CMP_TRUE = 2'h0, CMP_INV = 2'h1, CMP_ABS = 2'h2, CMP_PROG = 2'h3;
  localparam logic [1:0] B_ACC = 2'h0, B_MOR = 2'h1, B_ZERO = 2'h2;
  localparam logic [1:0] M_ACC = 2'h0, M_MOR = 2'h1, M_IO = 2'h2;
  localparam logic [2:0] F_NOP = 3'h0, F_SIGN = 3'h1, F_NSIGN = 3'h2, F_IX = 3'h3;
  localparam logic [2:0] F_IY = 3'h4, F_CLR = 3'h5, F_MOF = 3'h6, F_EOF = 3'h7;

  // 32-bit microcode word, msb first
  typedef struct packed {
    logic       spare;
    logic [2:0] fsm_cmd;
    logic       cond;      // write only when condition bit set
    logic       wr;        // write mir to data memory
    logic       mir_load;  // latch passes and loads mbus
    logic [1:0] mbus_sel;
    logic       acc_en;
    logic [1:0] b_sel;
    logic       a_prog;    // left input zero when condition bit clear
    logic       a_zero;
    logic [1:0] cmp_mode;
    logic       sor_en;    // unused bit kept for layout; sor always loads
    logic       sh_src;    // 0: mor, 1: sor
    logic [2:0] shamt;
    logic [1:0] mor_op;
    logic       idx_iy;
    logic       idx_ix;
    logic [DA_W-1:0] addr;
  } ucode_t;

  typedef enum logic [3:0] {
    sq_idle = 4'b0001, sq_main = 4'b0010, sq_sub = 4'b0100, sq_wait = 4'b1000
  } seq_t;

  typedef enum logic [1:0] {fsm_clr = 2'b01, fsm_set = 2'b10} fsm_t;

  typedef struct packed {
    logic [DW-1:0]   acc;
    logic [DW-1:0]   mor;
    logic [DW-1:0]   sor;
    logic [DW-1:0]   mir;
    logic [PC_W-1:0] pc;
    logic [IX_W-1:0] ix;
    logic [IX_W-1:0] iy;
    seq_t            seq;
    fsm_t            fsm;
    logic            eof;
    logic            mof;
    logic            ack;
    logic [31:0]     rdata;
    logic            run;
    logic [PC_W-1:0] main_len;
    logic [PC_W-1:0] sub_len;
    logic [IX_W-1:0] iter_mod;
    logic [IX_W-1:0] iy_mod;
    logic [IX_W-1:0] fsm_ref;
  } state_t;
endpackage

// ---- dsp_proc.sv ----
// one signal processor: data memory, pipelined datapath, sequencer and condition fsm

module dsp_proc
  import dsp_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          ce,
  input  wire logic          sample_start,
  input  wire logic [DW-1:0] io_in,
  output logic      [DW-1:0] result,
  output logic               frame_end,
  output logic               frame_mid,
  output logic               cond_bit,
  output logic               busy,
  input  wire logic [11:0]   address,
  input  wire logic          read,
  input  wire logic          write,
  input  wire logic [31:0]   writedata,
  output logic      [31:0]   readdata,
  output logic               waitrequest
);

  // storage arrays; microcode is loaded while stopped and then fixed
  logic [DW-1:0] dmem [DMEM_WORDS];
  logic [31:0]   ucode [UC_WORDS];

  state_t s_r;
  state_t s_nxt;

  // combinational datapath signals
  ucode_t        cw;
  logic          adv;
  logic [DA_W-1:0] daddr;
  logic [DW-1:0] sh_in;
  logic [DW-1:0] sh_out;
  logic [DW-1:0] a_bus;
  logic [DW-1:0] b_bus;
  logic [DW-1:0] sum;
  logic [DW-1:0] m_bus;
  logic [DW-1:0] mir_out;
  logic          cc;
  logic          dm_we;
  logic          bus_acc;
  logic [9:0]    widx;
  logic          bus_first;     // first cycle of an access: slave stalls
  logic          bus_done;      // second cycle: the master completes here
  logic          prog_stopped;  // run clear and sequencer idle
  logic [9:0]    reg_ofs;       // byte offset inside the register window
  logic [31:0]   rd_word;       // read data chosen for the current address
  logic          dm_bus_we;     // bus write into data memory
  logic          uc_bus_we;     // bus write into microcode

  // the absolute value of the most negative word wraps to itself; programs
  // that need a clean magnitude must keep one bit of headroom
  // complementer: true, inverse, absolute value or inverse chosen by the condition bit
  function automatic logic [DW-1:0] complement(input logic [DW-1:0] v,
                                               input logic [1:0] mode,
                                               input logic c);
    logic [DW-1:0] r;
    r = v;
    unique case (mode)
      CMP_TRUE: r = v;
      CMP_INV:  r = ~v;
      CMP_ABS:  r = v[DW-1] ? ~v + {{(DW-1){1'b0}}, 1'b1} : v;
      CMP_PROG: r = c ? ~v : v;  // sign chosen at run time for four-quadrant use
    endcase
    return r;
  endfunction

  // clipping instead of wrapping keeps a filter stable after an overflow;
  // one guard bit is enough because both operands are one word wide
  // overflow shows as a guard bit that differs from the sign bit
  // saturating two's-complement add
  function automatic logic [DW-1:0] sat_add(input logic [DW-1:0] a,
                                            input logic [DW-1:0] b);
    logic [DW:0] t;
    t = {a[DW-1], a} + {b[DW-1], b};
    if (t[DW] != t[DW-1]) begin
      return t[DW] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
    end
    return t[DW-1:0];
  endfunction

  // modulo increment shared by both index counters
  function automatic logic [IX_W-1:0] inc_mod(input logic [IX_W-1:0] v,
                                              input logic [IX_W-1:0] m);
    logic [IX_W-1:0] n;
    n = v + 8'h01;
    return (n == m) ? 8'h00 : n;
  endfunction

  // datapath advances only while the program runs and the enable is high
  assign adv     = ce && (s_r.seq == sq_main || s_r.seq == sq_sub);
  assign cw      = ucode_t'(ucode[s_r.pc]);
  assign cc      = (s_r.fsm == fsm_set);
  assign bus_acc = read || write;
  assign widx    = address[11:2];

  // access phases; a write lands only on the edge the master completes at
  assign bus_first    = bus_acc && !s_r.ack;
  assign bus_done     = bus_acc && s_r.ack;
  assign prog_stopped = !s_r.run && (s_r.seq == sq_idle);
  assign reg_ofs      = {address[9:2], 2'b00};
  assign dm_bus_we    = ce && write && bus_done && prog_stopped &&
                        (address[11:10] == DMEM_REGION) && !widx[7];
  assign uc_bus_we    = ce && write && bus_done && prog_stopped &&
                        (address[11:10] == UC_REGION);

  // both offsets may be added at once; the sum wraps inside the memory,
  // so tables that straddle the top word must be laid out by the programmer
  // indexed addressing adds either index to the address field
  always_comb begin
    logic [DA_W-1:0] ofs;
    ofs = '0;
    if (cw.idx_ix) begin
      ofs = ofs + s_r.ix[DA_W-1:0];
    end
    if (cw.idx_iy) begin
      ofs = ofs + s_r.iy[DA_W-1:0];
    end
    daddr = cw.addr + ofs;
  end

  // shifter, adder inputs and result bus
  always_comb begin
    sh_in  = cw.sh_src ? s_r.sor : s_r.mor;  // chained shifts via sor
    sh_out = DW'($signed(sh_in) >>> cw.shamt);
    if (cw.a_zero || (cw.a_prog && !cc)) begin
      a_bus = '0;
    end else begin
      a_bus = complement(s_r.sor, cw.cmp_mode, cc);
    end
    unique case (cw.b_sel)
      B_ACC:   b_bus = s_r.acc;
      B_MOR:   b_bus = s_r.mor;
      default: b_bus = '0;
    endcase
    sum = sat_add(a_bus, b_bus);
    unique case (cw.mbus_sel)
      M_MOR:   m_bus = s_r.mor;
      M_IO:    m_bus = io_in;
      default: m_bus = s_r.acc;  // accumulator is the default driver
    endcase
    // latch passes the bus in a loading cycle, else shows held value
    mir_out = (adv && cw.mir_load) ? m_bus : s_r.mir;
  end

  // a plain write ignores the condition bit; a conditional one is dropped
  // while the bit is clear, so the old word stays and the time per
  // sample never depends on data
  // condition bit gates the memory write enable
  assign dm_we = adv && cw.wr && (!cw.cond || cc);

  // read data for the addressed word; fetched in the stall cycle and
  // registered so readdata stands still from completion until the next read
  always_comb begin
    rd_word = '0;
    unique case (address[11:10])
      REG_REGION: begin
        unique case (reg_ofs)
          OFS_CTRL[9:0]:     rd_word = {31'h0, s_r.run};
          OFS_STATUS[9:0]:   rd_word = {4'h0, s_r.seq, s_r.iy, s_r.ix,
                                        7'h0, cc};
          OFS_MAIN_LEN[9:0]: rd_word = {24'h0, s_r.main_len};
          OFS_SUB_LEN[9:0]:  rd_word = {24'h0, s_r.sub_len};
          OFS_ITER_MOD[9:0]: rd_word = {24'h0, s_r.iter_mod};
          OFS_IY_MOD[9:0]:   rd_word = {24'h0, s_r.iy_mod};
          OFS_FSM_REF[9:0]:  rd_word = {24'h0, s_r.fsm_ref};
          OFS_RESULT[9:0]:   rd_word = {{(32-DW){s_r.mir[DW-1]}}, s_r.mir};
          default:           rd_word = '0;
        endcase
      end
      DMEM_REGION: begin
        if (!widx[7]) begin
          rd_word = {{(32-DW){dmem[widx[6:0]][DW-1]}}, dmem[widx[6:0]]};
        end
      end
      UC_REGION: rd_word = ucode[widx[7:0]];
      default:   rd_word = '0;
    endcase
  end

  // next-state logic for every register of the block
  always_comb begin
    logic last_main;
    logic last_sub;
    logic [PC_W-1:0] sub_end;
    s_nxt     = s_r;
    sub_end   = s_r.main_len + s_r.sub_len - 8'h01;
    last_main = (s_r.pc == s_r.main_len - 8'h01);
    last_sub  = (s_r.pc == sub_end);
    s_nxt.eof = 1'b0;
    s_nxt.mof = 1'b0;

    if (adv) begin
      // every stage reads the values of the previous cycle, so one
      // instruction sees the load register, shift register and accumulator
      // as the instructions before it left them; programs must allow for
      // that latency when they chain operations
      // four pipeline stages
      unique case (cw.mor_op)
        MOR_READ:    s_nxt.mor = dmem[daddr];
        MOR_INV_MIR: s_nxt.mor = ~s_r.mir;
        default:     s_nxt.mor = s_r.mor;
      endcase
      s_nxt.sor = sh_out;
      if (cw.acc_en) begin
        s_nxt.acc = sum;
      end
      s_nxt.mir = mir_out;

      // fsm command executes beside the datapath, no stall
      unique case (cw.fsm_cmd)
        F_SIGN:  s_nxt.fsm = s_r.acc[DW-1] ? fsm_set : fsm_clr;
        F_NSIGN: s_nxt.fsm = s_r.acc[DW-1] ? fsm_clr : fsm_set;
        F_IX:    s_nxt.fsm = (s_r.ix == s_r.fsm_ref) ? fsm_set : fsm_clr;
        F_IY:    s_nxt.fsm = (s_r.iy == s_r.fsm_ref) ? fsm_set : fsm_clr;
        F_CLR:   s_nxt.fsm = fsm_clr;
        F_MOF:   s_nxt.mof = 1'b1;
        F_EOF:   s_nxt.eof = 1'b1;
        default: s_nxt.fsm = s_r.fsm;
      endcase
    end

    // the program counter walks the main program once, then jumps back to
    // the start of the sub-program until the iteration index wraps; there
    // is no data-dependent jump, so a sample always costs
    // main_len + iter_mod * sub_len cycles
    // a start request while a program runs is ignored, not queued: the
    // host must keep its sample period longer than that cost
    // two counters, no branching: pc and iteration index
    if (ce) begin
      unique case (s_r.seq)
        sq_idle: begin
          if (s_r.run) begin
            s_nxt.seq = sq_wait;
          end
        end
        sq_wait: begin
          if (!s_r.run) begin
            s_nxt.seq = sq_idle;
          end else if (sample_start) begin
            s_nxt.seq = sq_main;  // main program once per sample
            s_nxt.pc  = '0;
            s_nxt.iy  = inc_mod(s_r.iy, s_r.iy_mod);
          end
        end
        sq_main: begin
          if (last_main) begin
            s_nxt.ix = '0;
            if (s_r.iter_mod == 8'h00 || s_r.sub_len == 8'h00) begin
              s_nxt.seq = sq_wait;
            end else begin
              s_nxt.seq = sq_sub;
              s_nxt.pc  = s_r.main_len;
            end
          end else begin
            s_nxt.pc = s_r.pc + 8'h01;
          end
        end
        sq_sub: begin
          if (last_sub) begin
            s_nxt.ix = inc_mod(s_r.ix, s_r.iter_mod);
            if (s_r.ix == s_r.iter_mod - 8'h01) begin
              s_nxt.seq = sq_wait;  // fixed count reached
            end else begin
              s_nxt.pc = s_r.main_len;
            end
          end else begin
            s_nxt.pc = s_r.pc + 8'h01;
          end
        end
        default: s_nxt.seq = sq_idle;
      endcase
    end

    // bus slave: one stall cycle, then the answer; reads are fetched in the
    // stall cycle, writes land at the completing edge only, so a write
    // that is aborted in the stall cycle changes nothing
    s_nxt.ack = bus_first;
    if (bus_first && read) begin
      s_nxt.rdata = rd_word;  // earlier read data stands across writes
    end
    if (bus_done && write && address[11:10] == REG_REGION) begin
      if (reg_ofs == OFS_CTRL[9:0]) begin
        s_nxt.run = writedata[0];
      end else if (prog_stopped) begin
        // program shape only changes while stopped
        unique case (reg_ofs)
          OFS_MAIN_LEN[9:0]: s_nxt.main_len = writedata[PC_W-1:0];
          OFS_SUB_LEN[9:0]:  s_nxt.sub_len  = writedata[PC_W-1:0];
          OFS_ITER_MOD[9:0]: s_nxt.iter_mod = writedata[IX_W-1:0];
          OFS_IY_MOD[9:0]:   s_nxt.iy_mod   = writedata[IX_W-1:0];
          OFS_FSM_REF[9:0]:  s_nxt.fsm_ref  = writedata[IX_W-1:0];
          default:           s_nxt.fsm_ref  = s_r.fsm_ref;
        endcase
      end
    end
    if (!ce) begin
      s_nxt = s_r;  // the enable freezes everything, bus included
    end
  end

  // reset ignores the enable so a frozen block can still be cleared;
  // memories keep their contents, software reloads them while stopped
  // index counters restart at zero; iy steps at each start, so the first sample sees iy one (iy_mod above one) and ix zero
  // state register, synchronous reset
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r          <= '0;
      s_r.seq      <= sq_idle;
      s_r.fsm      <= fsm_clr;
      s_r.main_len <= MAIN_LEN_RST;
      s_r.sub_len  <= SUB_LEN_RST;
      s_r.iter_mod <= ITER_MOD_RST;
      s_r.iy_mod   <= IY_MOD_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // memories; bus writes land only while stopped so the program owns them running
  always_ff @(posedge clk) begin
    if (dm_we) begin
      dmem[daddr] <= mir_out;
    end else if (dm_bus_we) begin
      dmem[widx[6:0]] <= writedata[DW-1:0];
    end
    if (uc_bus_we) begin
      ucode[widx[7:0]] <= writedata;
    end
  end

  // data outputs come straight from registers; waitrequest is the only
  // combinational output, it must answer the request in its own cycle
  // frame flags are single-cycle pulses while the enable stays high, the host counts them
  // outputs
  assign result      = s_r.mir;
  assign frame_end   = s_r.eof;
  assign frame_mid   = s_r.mof;
  assign cond_bit    = cc;
  assign busy        = (s_r.seq == sq_main) || (s_r.seq == sq_sub);
  assign readdata    = s_r.rdata;
  assign waitrequest = bus_acc && !s_r.ack;  // stalls first cycle of each access

endmodule // dsp_proc

// ---- dsp_proc_asserts.sv ----
// checker: port-level timing properties of the signal processor
module dsp_proc_asserts
  import dsp_pkg::*;
(
  input wire logic          clk,
  input wire logic          reset,
  input wire logic          ce,
  input wire logic          sample_start,
  input wire logic          read,
  input wire logic          write,
  input wire logic          waitrequest,
  input wire logic [31:0]   readdata,
  input wire logic          busy,
  input wire logic          frame_end,
  input wire logic          frame_mid,
  input wire logic          cond_bit,
  input wire logic [DW-1:0] result
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);

  // slave answers exactly one cycle after the request is seen
  bus_answer_a: assert property (ce && (read || write) && waitrequest ##1 ce |-> !waitrequest)
    else $error("bus request not answered after one cycle");
  bus_idle_a: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest high with no request");
  read_hold_a: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("read data moved without a read");
  // both flags come from one command field, so never together
  flags_excl_a: assert property (!(frame_end && frame_mid))
    else $error("frame end and frame middle together");
  flag_run_a: assert property ((frame_end || frame_mid) |-> $past(busy))
    else $error("frame flag without a running program");
  start_cause_a: assert property ($rose(busy) |-> $past(sample_start))
    else $error("program started without a sample start");
  // fsm and latch only move on instructions, which run while busy
  cond_hold_a: assert property (!$past(busy) |-> $stable(cond_bit))
    else $error("condition bit moved while idle");
  latch_hold_a: assert property (!$past(busy) |-> $stable(result))
    else $error("result latch moved while idle");

  // main scenarios reached
  cover property ($rose(busy));
  cover property (frame_end);
  cover property (frame_mid);
  cover property (write && !waitrequest);
endmodule // dsp_proc_asserts

bind dsp_proc dsp_proc_asserts chk (.clk(clk), .reset(reset), .ce(ce),
  .sample_start(sample_start), .read(read), .write(write), .waitrequest(waitrequest),
  .readdata(readdata), .busy(busy), .frame_end(frame_end), .frame_mid(frame_mid),
  .cond_bit(cond_bit), .result(result));

// ---- dsp_host_model.sv ----
// partner: sample timing source and host flag counter on the far side
module dsp_host_model
  import dsp_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        kick,
  input wire logic        busy,
  input wire logic        frame_end,
  input wire logic        frame_mid,
  output logic            sample_start,
  output logic [DW-1:0]   io_in,
  output int              n_end,
  output int              n_mid
);
  // start only between programs; input word changes every cycle so no stale value
  always_ff @(posedge clk) begin
    if (reset) begin
      sample_start <= 1'b0;
      io_in        <= 16'h0001;
      n_end        <= 0;
      n_mid        <= 0;
    end else begin
      sample_start <= kick & ~busy;
      io_in        <= {io_in[14:0], ~(io_in[15] ^ io_in[13])};
      n_end        <= n_end + int'(frame_end);
      n_mid        <= n_mid + int'(frame_mid);
    end
  end
endmodule // dsp_host_model

// ---- dsp_processor_datapath_sequencer_bench.sv ----
// bench: corner and random samples through the signal processor
module dsp_processor_datapath_sequencer_bench import dsp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic          clk, reset, ce, kick, read, write, sample_start;
  logic          busy, frame_end, frame_mid, cond_bit, waitrequest;
  logic [11:0]   address;
  logic [31:0]   writedata, readdata, q, r;
  logic [DW-1:0] io_in, result, x, y, sum;
  logic [2:0]    s;
  logic [1:0]    m;
  int            bad_count = 0, n_checks = 0, cyc, nb, e0, m0, n_end, n_mid;
  ucode_t        u[6];
  logic [11:0]   ro[8] = '{OFS_CTRL, OFS_STATUS, OFS_MAIN_LEN, OFS_SUB_LEN, OFS_ITER_MOD,
                           OFS_IY_MOD, OFS_FSM_REF, 12'h020};
  logic [31:0]   rv[8] = '{32'h0, 32'h0100_0000, 32'h1, 32'h1, 32'h1, 32'h1, 32'h0, 32'h0};

  dsp_proc dut (.clk(clk), .reset(reset), .ce(ce), .sample_start(sample_start),
    .io_in(io_in), .result(result), .frame_end(frame_end), .frame_mid(frame_mid),
    .cond_bit(cond_bit), .busy(busy), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
  dsp_host_model host (.clk(clk), .reset(reset), .kick(kick), .busy(busy),
    .frame_end(frame_end), .frame_mid(frame_mid), .sample_start(sample_start),
    .io_in(io_in), .n_end(n_end), .n_mid(n_mid));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] sx(input logic [DW-1:0] v);
    return {{16{v[15]}}, v};
  endfunction

  // expected accumulator: shift, complement, then saturating add
  function automatic logic [DW-1:0] sat_sum(input logic [DW-1:0] a0, b0,
                                            input logic [2:0] sh, input logic [1:0] md);
    logic [DW-1:0] a;
    logic [16:0]   t;
    a = $signed(a0) >>> sh;
    if (md == CMP_INV) a = ~a;
    else if (md == CMP_ABS && a[15]) a = -a;
    t = {a[15], a} + {b0[15], b0};
    if (t[16:15] == 2'b01) return 16'h7fff;
    if (t[16:15] == 2'b10) return 16'h8000;
    return t[15:0];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one bus access; held until the rising edge that sees waitrequest low, released there
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    int t;
    t = 0;
    @(posedge clk);
    address   <= a;
    writedata <= d;
    read      <= !w;
    write     <= w;
    do begin
      @(posedge clk);
      t++;
    end while (waitrequest !== 1'b0 && t < 20);
    rd = readdata;
    if (waitrequest !== 1'b0) bad_count++;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  // main: 2 loads, shift, add, latch and store, conditional store; sub: indexed store
  task automatic prog(input logic [2:0] sh, input logic [1:0] md);
    logic [31:0] q2;
    u = '{default: '0};
    u[0].mor_op = MOR_READ;
    u[1].mor_op = MOR_READ;
    u[1].addr = 7'h01;
    u[1].shamt = sh;
    u[2].cmp_mode = md;
    u[2].b_sel = B_MOR;
    u[2].acc_en = 1'b1;
    u[3].mir_load = 1'b1;
    u[3].wr = 1'b1;
    u[3].addr = 7'h02;
    u[3].fsm_cmd = F_SIGN;
    u[4].wr = 1'b1;
    u[4].cond = 1'b1;
    u[4].addr = 7'h03;
    u[4].fsm_cmd = F_EOF;
    u[5].wr = 1'b1;
    u[5].idx_ix = 1'b1;
    u[5].addr = 7'h08;
    u[5].fsm_cmd = F_MOF;
    for (int i = 0; i < 6; i++) bus(1'b1, 12'h800 + 12'(4 * i), u[i], q2);
  endtask

  // hang guard
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 5000) begin
        bad_count++;
        end_sim;
      end
    end
  end

  // first two samples hit both saturation limits, the rest are random
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    kick = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 12'h000;
    writedata = 32'h0;
    r = 32'h0001_6272;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ro[i], 32'h0, q);
      chk(q, rv[i]);
    end
    bus(1'b1, OFS_MAIN_LEN, 32'h5, q);
    bus(1'b1, OFS_SUB_LEN, 32'h1, q);
    bus(1'b1, OFS_ITER_MOD, 32'h3, q);
    bus(1'b1, OFS_IY_MOD, 32'h4, q);
    for (int k = 0; k < 8; k++) begin
      r = lfsr(lfsr(r));
      x = (k < 2) ? 16'h7fff : {1'b0, r[14:0]};
      y = (k == 0) ? 16'h7fff : (k == 1) ? 16'h8000 : r[31:16];
      s = (k < 2) ? 3'h0 : r[18:16];
      m = (k == 0) ? CMP_TRUE : (k == 1) ? CMP_INV : 2'(r[7:0] % 3);
      sum = sat_sum(x, y, s, m);
      bus(1'b1, OFS_CTRL, 32'h0, q);
      bus(1'b1, 12'h400, {16'h0, x}, q);
      bus(1'b1, 12'h404, {16'h0, y}, q);
      bus(1'b1, 12'h40c, {16'h0, ~r[15:0]}, q);
      prog(s, m);
      bus(1'b1, OFS_CTRL, 32'h1, q);
      bus(1'b1, 12'h404, {16'h0, ~y}, q);
      e0 = n_end;
      m0 = n_mid;
      nb = 0;
      kick <= 1'b1;
      @(posedge clk);
      kick <= 1'b0;
      repeat (40) begin
        @(negedge clk);
        if (busy === 1'b1) nb++;
      end
      chk(32'(nb), 32'h8);
      chk(sx(result), sx(sum));
      chk({31'h0, cond_bit}, {31'h0, sum[15]});
      bus(1'b0, 12'h408, 32'h0, q);
      chk(q, sx(sum));
      bus(1'b0, 12'h40c, 32'h0, q);
      chk(q, sx(sum[15] ? sum : ~r[15:0]));
      for (int i = 0; i < 3; i++) begin
        bus(1'b0, 12'h420 + 12'(4 * i), 32'h0, q);
        chk(q, sx(sum));
      end
      bus(1'b0, 12'h404, 32'h0, q);
      chk(q, sx(y));
      bus(1'b0, OFS_STATUS, 32'h0, q);
      chk(q & 32'h0fff_0001, {8'h08, 8'((k + 1) % 4), 15'h0, sum[15]});
      chk(32'(n_end - e0), 32'h1);
      chk(32'(n_mid - m0), 32'h3);
    end
    end_sim;
  end
endmodule // dsp_processor_datapath_sequencer_bench
